// ==== rtl/comc_top.v ====
// configurable output macrocell device: config memory, security and eight output cells
// ==========================================
// Behaviour
// RQ1: each output cell selects polarity and combinational or registered operation; here the outermost two cells are never registered.
// RQ2: sync mode bit enables registered capability or forces combinational outputs.
// RQ3: outermost two cells use the sync mode bit instead of global arch.
// RQ4: one 82-bit configuration word at row 60 holds all cell settings.
// RQ5: arch bits choose always driven, input, common enable or term enable.
// RQ6: arch bits steer the feedback selector source.
// RQ7: polarity bit 0 gives active low, 1 gives active high.
// RQ8: sync 1, global 0, cell 1: input mode, buffer off.
// RQ9: sync 1, global 0, cell 0: combinational, always driven.
// RQ10: sync 1, global 1, cell 1: all outputs combinational.
// RQ11: sync 0, global 1, cell 1: combinational cell in registered device.
// RQ12: sync 0, global 1, cell 0: registered output with polarity.
// RQ13: 44 user rows; rows 0 to 39 hold 64-bit array data.
// RQ14: row 40 signature readable regardless of security.
// RQ15: programmer must not use rows 41 to 59.
// RQ16: row 61 security bit blocks programming and readback of rows 0-39.
// RQ17: security bit cleared only with the array by bulk erase.
// RQ18: addressing row 63 when programming bulk-erases everything.
// RQ19: at reset register outputs go low so enabled pins read high.
// RQ20: registered cells capture on clock edge, drive only with enable low.
`include "comc_map.vh"
module comc_top #(
	parameter CELLS   = 8,
	parameter ROWS    = 40,
	parameter ROW_W   = `COMC_ROW_BITS,
	parameter CFG_W   = `COMC_CFG_BITS
) (
	input  wire                   clk_sys,
	input  wire                   rst,
	input  wire [`COMC_CMD_W-1:0] prog_cmd,
	input  wire [`COMC_ROW_W-1:0] prog_row,
	input  wire [CFG_W-1:0]       prog_wdata,
	output reg  [CFG_W-1:0]       prog_rdata,
	output reg                    prog_done,
	output reg                    prog_refused,
	output reg                    secured,
	input  wire [CELLS-1:0]       sum_term,
	input  wire [CELLS-1:0]       enable_term,
	input  wire                   oe_pin_n,
	input  wire                   clk_pin,
	input  wire [CELLS-1:0]       pin_in,
	output reg  [CELLS-1:0]       pin_out,
	output reg  [CELLS-1:0]       pin_oe,
	output reg  [CELLS-1:0]       feedback,
	output reg                    ded_clk_data,
	output reg                    ded_oe_data,
	output reg  [CELLS-1:0]       cell_registered
);
	// ==========================================
	// programming decode
	reg  [CFG_W-1:0] cfg_word;
	reg              sec_bit;
	reg  [ROW_W-1:0] sig_row;
	wire [ROW_W-1:0] array_q [0:ROWS-1];
	wire is_wr    = (prog_cmd == `COMC_CMD_WRITE);
	wire is_rd    = (prog_cmd == `COMC_CMD_READ);
	wire row_arr  = (prog_row <= `COMC_ROW_ARRAY_LAST);
	wire row_rsv  = (prog_row >= `COMC_ROW_RSV_FIRST) && (prog_row <= `COMC_ROW_RSV_LAST);
	wire erase    = is_wr && (prog_row == `COMC_ROW_ERASE); // RQ18
	wire blocked  = sec_bit && row_arr && (is_wr || is_rd); // RQ16
	// reserved rows are refused so a stray programmer access cannot disturb anything
	wire refuse   = blocked || ((is_wr || is_rd) && row_rsv); // RQ15
	wire arr_wr   = is_wr && row_arr && !sec_bit; // RQ13 RQ16

	genvar g;
	generate
		for (g = 0; g < ROWS; g = g + 1) begin : g_row
			localparam [`COMC_ROW_W-1:0] ROW_IDX = g;
			comc_row #(.W(ROW_W)) u_row (
				.clk_sys (clk_sys),
				.rst     (rst),
				.wr      (arr_wr && (prog_row == ROW_IDX)),
				.erase   (erase),
				.wdata   (prog_wdata[ROW_W-1:0]),
				.q       (array_q[g])
			);
		end
	endgenerate

	// ==========================================
	// signature, configuration word and security cell
	always @(posedge clk_sys) begin
		if (erase) begin
			sig_row  <= `COMC_BLANK_ROW; // RQ18
			cfg_word <= `COMC_BLANK_CFG; // RQ18
			sec_bit  <= 1'b0; // RQ17
		end else if (is_wr) begin
			if (prog_row == `COMC_ROW_SIG)
				sig_row <= prog_wdata[ROW_W-1:0]; // RQ14
			if (prog_row == `COMC_ROW_CFG && !sec_bit)
				cfg_word <= prog_wdata; // RQ4
			if (prog_row == `COMC_ROW_SEC)
				sec_bit <= sec_bit | prog_wdata[0]; // RQ16
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			prog_rdata   <= {CFG_W{1'b0}};
			prog_done    <= 1'b0;
			prog_refused <= 1'b0;
			secured      <= 1'b0;
		end else begin
			prog_done    <= (is_wr || is_rd) && !refuse;
			prog_refused <= refuse;
			secured      <= sec_bit;
			if (is_rd && !refuse) begin
				if (row_arr)
					prog_rdata <= {{(CFG_W-ROW_W){1'b0}}, array_q[prog_row]};
				else if (prog_row == `COMC_ROW_SIG)
					prog_rdata <= {{(CFG_W-ROW_W){1'b0}}, sig_row}; // RQ14
				else if (prog_row == `COMC_ROW_CFG)
					prog_rdata <= cfg_word;
				else if (prog_row == `COMC_ROW_SEC)
					prog_rdata <= {{(CFG_W-1){1'b0}}, sec_bit};
				else
					prog_rdata <= {CFG_W{1'b0}};
			end
		end
	end

	// ==========================================
	// output cells
	wire sync_mode_bit   = cfg_word[`COMC_CFG_SYNC];
	wire global_arch_bit = cfg_word[`COMC_CFG_GARCH];
	wire [CELLS-1:0] c_out;
	wire [CELLS-1:0] c_oe;
	wire [CELLS-1:0] c_fb;
	wire [CELLS-1:0] c_reg;
	// pin synchronous to clk_sys; a rising edge of the shared clock pin clocks the cells
	reg  clk_pin_q;
	wire clk_rise = clk_pin & ~clk_pin_q; // RQ20
	always @(posedge clk_sys) begin
		if (rst)
			clk_pin_q <= 1'b0;
		else
			clk_pin_q <= clk_pin;
	end

	generate
		for (g = 0; g < CELLS; g = g + 1) begin : g_cell
			// outer cells swap the global arch bit for the sync mode bit
			wire garch = (g == 0 || g == CELLS-1) ? sync_mode_bit : global_arch_bit; // RQ3
			comc_cell u_cell (
				.clk_sys            (clk_sys),
				.rst                (rst),
				.sync_mode_bit      (sync_mode_bit),
				.global_arch_bit    (garch),
				.cell_arch_bit      (cfg_word[`COMC_CFG_ARCH_LSB+g]),
				.neighbour_arch_bit (cfg_word[`COMC_CFG_ARCH_LSB+((g+1)%CELLS)]),
				.polarity_bit       (cfg_word[`COMC_CFG_POL_LSB+g]),
				.sum_term           (sum_term[g]),
				.enable_term        (enable_term[g]),
				.oe_pin_n           (oe_pin_n),
				.clk_edge           (clk_rise),
				.pin_in             (pin_in[g]),
				.neighbour_pin_in   (pin_in[(g+1)%CELLS]),
				.pin_out            (c_out[g]),
				.pin_oe             (c_oe[g]),
				.feedback           (c_fb[g]),
				.is_registered      (c_reg[g]),
				.is_input           ()
			);
		end
	endgenerate

	// ==========================================
	// pin outputs
	always @(posedge clk_sys) begin
		if (rst) begin
			pin_out         <= {CELLS{1'b1}}; // RQ19
			pin_oe          <= {CELLS{1'b0}};
			feedback        <= {CELLS{1'b0}};
			ded_clk_data    <= 1'b0;
			ded_oe_data     <= 1'b0;
			cell_registered <= {CELLS{1'b0}};
		end else begin
			pin_out         <= c_out;
			pin_oe          <= c_oe;
			feedback        <= c_fb;
			// dedicated pins are plain data inputs when the sync mode bit is set
			ded_clk_data    <= sync_mode_bit & clk_pin; // RQ8 RQ9 RQ10
			ded_oe_data     <= sync_mode_bit & ~oe_pin_n; // RQ11
			cell_registered <= c_reg;
		end
	end
endmodule

// ==== rtl/comc_map.vh ====
// constants for the configurable output macrocell block
`ifndef COMC_MAP_VH
`define COMC_MAP_VH
// ==========================================
// configuration memory rows
`define COMC_ROW_W          6
`define COMC_ROW_ARRAY_LAST 6'h27
`define COMC_ROW_SIG        6'h28
`define COMC_ROW_RSV_FIRST  6'h29
`define COMC_ROW_RSV_LAST   6'h3b
`define COMC_ROW_CFG        6'h3c
`define COMC_ROW_SEC        6'h3d
`define COMC_ROW_ERASE      6'h3f
`define COMC_ROW_BITS       64
`define COMC_CFG_BITS       82
// ==========================================
// configuration word fields
`define COMC_CFG_POL_LSB    0
`define COMC_CFG_ARCH_LSB   8
`define COMC_CFG_GARCH      16
`define COMC_CFG_SYNC       17
// ==========================================
// reset and blank values
`define COMC_BLANK_ROW      64'h0000000000000000
`define COMC_BLANK_CFG      82'h0
`define COMC_ZERO_ROW       64'h0000000000000000
// ==========================================
// programming commands
`define COMC_CMD_W          2
`define COMC_CMD_NONE       2'h0
`define COMC_CMD_WRITE      2'h1
`define COMC_CMD_READ       2'h2
`endif

// ==== rtl/comc_cell.v ====
// one output cell: mode decode, polarity, register, enable and feedback selection
`include "comc_map.vh"
module comc_cell (
	input  wire clk_sys,
	input  wire rst,
	input  wire sync_mode_bit,
	input  wire global_arch_bit,
	input  wire cell_arch_bit,
	input  wire neighbour_arch_bit,
	input  wire polarity_bit,
	input  wire sum_term,
	input  wire enable_term,
	input  wire oe_pin_n,
	input  wire clk_edge,
	input  wire pin_in,
	input  wire neighbour_pin_in,
	output reg  pin_out,
	output reg  pin_oe,
	output reg  feedback,
	output reg  is_registered,
	output reg  is_input
);
	// ==========================================
	// mode decode
	reg state_q;
	reg next_pin_out;
	reg next_pin_oe;
	reg next_feedback;
	reg next_state;
	wire reg_mode = ~sync_mode_bit & global_arch_bit & ~cell_arch_bit; // RQ2 RQ12
	wire in_mode  = sync_mode_bit & ~global_arch_bit & cell_arch_bit; // RQ8
	wire ptc_mode = global_arch_bit & cell_arch_bit; // RQ5 RQ10 RQ11
	// polarity xor: 0 gives active low, 1 active high
	wire comb_val = polarity_bit ? sum_term : ~sum_term; // RQ1 RQ7

	// ==========================================
	// register, cleared at reset so an enabled registered pin comes up high
	always @(posedge clk_sys) begin
		if (rst)
			state_q <= 1'b0; // RQ19
		else
			state_q <= next_state; // RQ20
	end

	always @* begin
		next_state    = state_q;
		next_pin_out  = comb_val;
		next_pin_oe   = 1'b1; // RQ9
		next_feedback = pin_in;
		if (reg_mode) begin
			// pin drives the inverted register output
			next_pin_out  = ~state_q;
			// q is stored inverted so the pin shows the chosen polarity; held between edges
			if (clk_edge)
				next_state = polarity_bit ? ~sum_term : sum_term; // RQ7 RQ20
			next_pin_oe   = ~oe_pin_n; // RQ20
			next_feedback = state_q; // RQ6
		end else if (in_mode) begin
			next_pin_oe   = 1'b0; // RQ8
			next_feedback = pin_in;
		end else if (ptc_mode) begin
			next_pin_oe   = enable_term; // RQ5
			next_feedback = pin_in;
		end else begin
			// always-on output: feedback comes from the adjacent pin when its arch bit is set, else 0
			next_feedback = neighbour_arch_bit ? neighbour_pin_in : 1'b0; // RQ6
		end
	end

	// outputs registered: adds one cycle of latency to every combinational path
	always @(posedge clk_sys) begin
		if (rst) begin
			pin_out       <= 1'b1; // RQ19
			pin_oe        <= 1'b0;
			feedback      <= 1'b0;
			is_registered <= 1'b0;
			is_input      <= 1'b0;
		end else begin
			pin_out       <= next_pin_out;
			pin_oe        <= next_pin_oe;
			feedback      <= next_feedback;
			is_registered <= reg_mode;
			is_input      <= in_mode;
		end
	end
endmodule

// ==== rtl/comc_row.v ====
// one 64-bit row of programmable storage with erase
`include "comc_map.vh"
module comc_row #(
	parameter W = `COMC_ROW_BITS
) (
	input  wire         clk_sys,
	input  wire         rst,
	input  wire         wr,
	input  wire         erase,
	input  wire [W-1:0] wdata,
	output reg  [W-1:0] q
);
	// ==========================================
	// storage survives rst; only bulk erase blanks it, like nonvolatile cells
	always @(posedge clk_sys) begin
		if (erase)
			q <= {W{1'b0}};
		else if (wr)
			q <= wdata;
	end
endmodule

// ==== testbench/comc_prog.sv ====
// programmer model driving row commands into the device
`include "comc_map.vh"
module comc_prog (
	input  logic        clk_sys,
	output logic [1:0]  prog_cmd,
	output logic [5:0]  prog_row,
	output logic [81:0] prog_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// commands
	initial begin
		prog_cmd = `COMC_CMD_NONE;
		prog_row = 6'h00;
		prog_wdata = 82'h0;
	end
	// held for one edge; no release so back to back commands stay legal
	task automatic op(input logic [1:0] c, input logic [5:0] r, input logic [81:0] d);
		prog_cmd = c;
		prog_row = r;
		prog_wdata = d;
		@(posedge clk_sys);
		#1;
	endtask
	// released data is inverted so a stale word never looks fresh
	task automatic idle();
		prog_cmd = `COMC_CMD_NONE;
		prog_wdata = ~prog_wdata;
		@(posedge clk_sys);
		#1;
	endtask
endmodule

// ==== testbench/comc_top_chk.sv ====
// assertion checker for the macrocell device ports
`include "comc_map.vh"
module comc_chk #(
	parameter CELLS = 8,
	parameter CFG_W = `COMC_CFG_BITS
) (
	input logic                   clk_sys,
	input logic                   rst,
	input logic [`COMC_CMD_W-1:0] prog_cmd,
	input logic [`COMC_ROW_W-1:0] prog_row,
	input logic [CFG_W-1:0]       prog_wdata,
	input logic                   prog_done,
	input logic                   prog_refused,
	input logic                   secured,
	input logic [CELLS-1:0]       pin_out,
	input logic [CELLS-1:0]       pin_oe,
	input logic                   oe_pin_n,
	input logic [CELLS-1:0]       cell_registered
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========
	// properties
	sequence s_cmd;
		prog_cmd != `COMC_CMD_NONE;
	endsequence
	sequence s_sec_set;
		prog_cmd == `COMC_CMD_WRITE && prog_row == `COMC_ROW_SEC && prog_wdata[0];
	endsequence
	chk_cmd_answer: assert property (s_cmd |=> prog_done != prog_refused)
		else $error("command gave no single answer");
	chk_idle_quiet: assert property (!prog_cmd |=> !prog_done && !prog_refused)
		else $error("answer without command");
	chk_rsv_refuse: assert property (s_cmd ##0 prog_row >= `COMC_ROW_RSV_FIRST
		&& prog_row <= `COMC_ROW_RSV_LAST |=> prog_refused)
		else $error("reserved row accepted");
	// secured lags the cell by one edge, so skip the cycle right after an erase
	chk_sec_refuse: assert property (s_cmd ##0 secured && prog_row <= `COMC_ROW_ARRAY_LAST
		&& !($past(prog_cmd) == `COMC_CMD_WRITE && $past(prog_row) == `COMC_ROW_ERASE)
		|=> prog_refused)
		else $error("secured array row accepted");
	chk_sig_open: assert property (prog_cmd == `COMC_CMD_READ && prog_row == `COMC_ROW_SIG
		|=> prog_done)
		else $error("signature read refused");
	chk_sec_set: assert property (s_sec_set ##0 !secured |-> ##[1:2] secured)
		else $error("security bit not set");
	chk_erase_clear: assert property (prog_cmd == `COMC_CMD_WRITE
		&& prog_row == `COMC_ROW_ERASE |-> ##[1:2] !secured)
		else $error("erase left security set");
	chk_reset_pins: assert property ($fell(rst) |-> &pin_out && !pin_oe)
		else $error("pins not at reset level");
	// mode flag and enable both pass two register stages, so look two edges back
	chk_reg_enable: assert property (|(cell_registered & pin_oe) |-> !$past(oe_pin_n, 2))
		else $error("registered pin driven while enable high");
endmodule
bind comc_top comc_chk #(.CELLS(CELLS), .CFG_W(CFG_W)) u_chk (.clk_sys, .rst, .prog_cmd,
	.prog_row, .prog_wdata, .prog_done, .prog_refused, .secured, .pin_out, .pin_oe,
	.oe_pin_n, .cell_registered);

// ==== testbench/comc_tb_top.sv ====
// self-checking bench for the macrocell device
`include "comc_map.vh"
module comc_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys, rst, oe_pin_n, clk_pin, prog_done, prog_refused, secured;
	logic [1:0]  prog_cmd;
	logic [5:0]  prog_row;
	logic [81:0] prog_wdata, prog_rdata;
	logic [7:0]  sum_term, enable_term, pin_in, pin_out, pin_oe, pol;
	logic [7:0]  feedback, cell_registered;
	logic        ded_clk_data, ded_oe_data;
	logic [63:0] d0, d1;
	logic [65:0] exp_q[$];
	logic [65:0] e;
	int          n_errors = 0, num_checks = 0, cyc = 0;
	comc_prog prog (.clk_sys, .prog_cmd, .prog_row, .prog_wdata);
	comc_top dut (.clk_sys, .rst, .prog_cmd, .prog_row, .prog_wdata, .prog_rdata, .prog_done,
		.prog_refused, .secured, .sum_term, .enable_term, .oe_pin_n, .clk_pin, .pin_in,
		.pin_out, .pin_oe, .feedback, .ded_clk_data, .ded_oe_data, .cell_registered);
	// ==========
	// clock, timeout, monitor
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			results();
		end
	end
	initial forever begin
		@(posedge clk_sys);
		#2;
		if (prog_done === 1'h1 || prog_refused === 1'h1) begin
			e = exp_q.pop_front();
			check("refused", e[65], prog_refused);
			if (e[64])
				check("rdata", e[63:0], prog_rdata[63:0]);
		end
	end
	task automatic check(input string w, input logic [81:0] x, input logic [81:0] a);
		num_checks++;
		if (x !== a) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", w, x, a);
		end
	endtask
	// f: bit1 refusal expected, bit0 read data compared
	task automatic cmd(input logic [1:0] c, input logic [5:0] r, input logic [63:0] d,
		input logic [1:0] f);
		exp_q.push_back({f, d});
		prog.op(c, r, {18'h0, d});
	endtask
	// pins settle through cell and output registers
	task automatic pins(input logic [7:0] eo, input logic [7:0] ep, input logic [7:0] ef,
		input logic [7:0] er);
		repeat (3) @(posedge clk_sys);
		#1;
		check("pin_oe", eo, pin_oe);
		check("pin_out", ep & eo, pin_out & eo);
		check("feedback", ef, feedback);
		check("cell_registered", er, cell_registered);
	endtask
	// ==========
	// scenarios
	initial begin
		{rst, oe_pin_n, clk_pin} = 3'h6;
		{sum_term, enable_term, pin_in} = 24'h0;
		void'($urandom(82));
		repeat (20) @(posedge clk_sys);
		#1;
		rst = 1'h0;
		d0 = {$urandom, $urandom};
		d1 = {$urandom, $urandom};
		cmd(`COMC_CMD_WRITE, `COMC_ROW_ERASE, 64'h0, 2'h0);
		cmd(`COMC_CMD_WRITE, 6'h05, d0, 2'h0);
		cmd(`COMC_CMD_WRITE, `COMC_ROW_ARRAY_LAST, d1, 2'h0);
		cmd(`COMC_CMD_WRITE, `COMC_ROW_SIG, d1, 2'h0);
		cmd(`COMC_CMD_READ, 6'h05, d0, 2'h1);
		cmd(`COMC_CMD_READ, `COMC_ROW_ARRAY_LAST, d1, 2'h1);
		cmd(`COMC_CMD_READ, `COMC_ROW_RSV_FIRST, 64'h0, 2'h2);
		cmd(`COMC_CMD_WRITE, `COMC_ROW_RSV_LAST, 64'h0, 2'h2);
		cmd(`COMC_CMD_WRITE, `COMC_ROW_SEC, 64'h1, 2'h0);
		repeat (2) prog.idle();
		check("secured", 82'h1, secured);
		cmd(`COMC_CMD_READ, 6'h05, 64'h0, 2'h2);
		cmd(`COMC_CMD_WRITE, 6'h00, d0, 2'h2);
		cmd(`COMC_CMD_READ, `COMC_ROW_SIG, d1, 2'h1);
		cmd(`COMC_CMD_WRITE, `COMC_ROW_ERASE, 64'h0, 2'h0);
		repeat (2) prog.idle();
		check("secured", 82'h0, secured);
		cmd(`COMC_CMD_READ, 6'h05, 64'h0, 2'h1);
		cmd(`COMC_CMD_READ, `COMC_ROW_SIG, 64'h0, 2'h1);
		{pol, sum_term, enable_term, pin_in} = $urandom;
		cmd(`COMC_CMD_WRITE, `COMC_ROW_CFG, {46'h0, 10'h200, pol}, 2'h0);
		prog.idle();
		pins(8'hff, ~(sum_term ^ pol), 8'h00, 8'h00);
		{oe_pin_n, clk_pin} = 2'h1;
		cmd(`COMC_CMD_WRITE, `COMC_ROW_CFG, {46'h0, 10'h2ff, pol}, 2'h0);
		prog.idle();
		pins(enable_term & 8'h81, ~(sum_term ^ pol), pin_in, 8'h00);
		check("ded_clk_data", 82'h1, ded_clk_data);
		check("ded_oe_data", 82'h1, ded_oe_data);
		cmd(`COMC_CMD_WRITE, `COMC_ROW_CFG, {46'h0, 10'h100, pol}, 2'h0);
		prog.idle();
		{rst, oe_pin_n, clk_pin} = 3'h4;
		prog.idle();
		rst = 1'h0;
		pins(8'hff, ~(sum_term ^ pol) | 8'h7e, 8'h00, 8'h7e);
		check("ded_oe_data", 82'h0, ded_oe_data);
		clk_pin = 1'h1;
		prog.idle();
		pins(8'hff, ~(sum_term ^ pol), (sum_term ^ pol) & 8'h7e, 8'h7e);
		check("ded_clk_data", 82'h0, ded_clk_data);
		sum_term = ~sum_term;
		pins(8'hff, ~(sum_term ^ pol) ^ 8'h7e, ~(sum_term ^ pol) & 8'h7e, 8'h7e);
		oe_pin_n = 1'h1;
		pins(8'h81, ~(sum_term ^ pol), ~(sum_term ^ pol) & 8'h7e, 8'h7e);
		check("pending", 82'h0, exp_q.size());
		results();
	end
	task automatic results();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
endmodule
